// ### rtl/rstctl_pkg.sv
/*
 * Constants, register map and state type of the reset source controller.
 * Assumes a single 20 MHz clock; all times are converted to cycles here.
 */
package rstctl_pkg;

    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [7:0] MON_CTRL_ADDR = 8'hff;
    localparam logic [7:0] RST_SRC_ADDR = 8'hef;
    localparam int MON_EN_BIT = 7;
    localparam int SUPPLY_OK_BIT = 6;

    // Reset source register bit positions
    localparam int RS_PIN = 0;
    localparam int RS_PWR = 1;
    localparam int RS_CLK = 2;
    localparam int RS_WDT = 3;
    localparam int RS_SW = 4;
    localparam int RS_CMP = 5;
    localparam int RS_MEM = 6;
    localparam int RS_USB = 7;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic MON_EN_RESET = 1'b1;
    localparam logic SUPPLY_SEL_RESET = 1'b1;
    localparam logic [7:0] FLAGS_POR = 8'(1 << RS_PWR);

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 50;
    localparam int POR_DELAY_NS = 300000;
    localparam int POR_DELAY_CYC = (POR_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MCD_TIMEOUT_NS = 100000;
    localparam int MCD_TIMEOUT_CYC = MCD_TIMEOUT_NS / CLK_PERIOD_NS;
    localparam int HOLD_MIN_CYC = 8;
    localparam int WDT_DIV = 12;
    localparam int PIN_MASK_CYC = 4;

    // ----------------------------------------
    // Synchronised pin lanes
    // ----------------------------------------
    localparam int SI_PIN = 0;
    localparam int SI_SUP = 1;
    localparam int SI_CMP = 2;
    localparam int SI_VBUS = 3;
    localparam int SI_CLK = 4;
    localparam int SYNC_W = 5;
    localparam logic [SYNC_W-1:0] SYNC_RESET = 5'h03;

    typedef enum logic [2:0] {
        ST_POR = 3'b001,
        ST_HOLD = 3'b010,
        ST_RUN = 3'b100
    } state_t;

endpackage : rstctl_pkg

// ### rtl/sync_if.sv
/*
 * Carrier between the controller and its pin synchroniser.
 * Assumes raw lanes come from pins outside the clock domain.
 */
interface sync_if #(
    parameter int W = 1
);
    logic [W-1:0] raw;
    logic [W-1:0] filt;

    modport syncer (input raw, output filt);
    modport user (output raw, input filt);
endinterface : sync_if

// ### rtl/pin_sync.sv
/*
 * Three-stage pin synchroniser with agreement filter.
 * Assumes raw lanes are asynchronous; filtered lanes are clock_in aligned.
 */
module pin_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RESET_VAL = '0
) (
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_n_in,
    // Lanes
    sync_if.syncer lanes
);

    logic [W-1:0] s1_q, s2_q, s3_q, filt_q;
    logic [W-1:0] s1_d, s2_d, s3_d, filt_d;

    // Stage one feeds stage two only; a change counts once two and three agree
    always_comb begin
        s1_d = lanes.raw;
        s2_d = s1_q;
        s3_d = s2_q;
        filt_d = ((s2_q ~^ s3_q) & s3_q) | ((s2_q ^ s3_q) & filt_q);
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s1_q <= RESET_VAL;
            s2_q <= RESET_VAL;
            s3_q <= RESET_VAL;
            filt_q <= RESET_VAL;
        end else begin
            s1_q <= s1_d;
            s2_q <= s2_d;
            s3_q <= s3_d;
            filt_q <= filt_d;
        end
    end

    assign lanes.filt = filt_q;

endmodule : pin_sync

// ### rtl/sat_counter.sv
/*
 * Saturating cycle counter, flags when LIMIT cycles have run.
 * Assumes clear has priority over run.
 */
module sat_counter #(
    parameter int LIMIT = 1
) (
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_n_in,
    // Control
    input wire logic clear_in,
    input wire logic run_in,
    // Status
    output logic done_out
);

    localparam int W = $clog2(LIMIT + 1);
    localparam logic [W-1:0] LIM = W'(LIMIT);

    logic [W-1:0] cnt_q, cnt_d;

    always_comb begin
        cnt_d = cnt_q;
        if (clear_in) begin
            cnt_d = '0;
        end else if (run_in && cnt_q != LIM) begin
            cnt_d = cnt_q + 1'b1;
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign done_out = (cnt_q == LIM);

endmodule : sat_counter

// ### rtl/reset_source_controller.sv
/*
 * Reset source controller: merges reset requests into one core reset,
 * records the cause and drives the open-drain reset pin.
 * Assumes rst_n_in is the power-on reset and the register port master
 * follows the one-cycle strobe protocol.
 */
// Design decision made here: the plain strobed port.
// Functional notes
// - Supply low drives pin, holds core
// - Monitor enable survives all non-power-on resets
// - Supply reset needs enable and selection
// - No power-on delay after supply reset
// - Status bit shows supply above threshold
// - Low six monitor bits inert
// - Pin low resets, sets pin flag
// - Stuck system clock causes reset
// - Clock-loss enable write, flag read
// - Internal resets leave pin alone
// - Comparator low input resets when enabled
// - Comparator flag only after comparator reset
// - Watchdog enabled, divide-by-twelve after reset
// - Code access above limit resets, flags
// - Software force bit resets, flags
// - USB bus reset or VBUS edge resets
// - USB flag after USB reset
// - Power flag set clears others' meaning
// - Watchdog flag bit three, read-only
module reset_source_controller #(
    parameter int POR_DELAY_CYC = rstctl_pkg::POR_DELAY_CYC,
    parameter int MCD_TIMEOUT_CYC = rstctl_pkg::MCD_TIMEOUT_CYC,
    parameter int ADDR_W = 16,
    parameter logic [ADDR_W-1:0] CODE_LIMIT = 16'h7fff
) (
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_n_in,
    // Register port
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wr_data_in,
    input wire logic wr_en_in,
    input wire logic rd_en_in,
    output logic [7:0] rd_data_out,
    // Reset pin, open drain
    input wire logic rst_pin_n_in,
    output logic rst_pin_out,
    output logic rst_pin_oe_out,
    // Asynchronous sources
    input wire logic supply_above_in,
    input wire logic comp_below_in,
    input wire logic vbus_in,
    input wire logic sys_clk_mon_in,
    // Same-clock sources
    input wire logic wdt_overflow_in,
    input wire logic wdt_disable_in,
    input wire logic code_access_in,
    input wire logic [ADDR_W-1:0] code_addr_in,
    input wire logic usb_func_en_in,
    input wire logic usb_bus_reset_in,
    input wire logic vbus_polarity_in,
    // Core side
    output logic core_rst_n_out,
    output logic monitor_enable_out,
    output logic wdt_enable_out,
    output logic wdt_tick_out
);

    // ----------------------------------------
    // Pin synchronisers and timers
    // ----------------------------------------
    sync_if #(.W(rstctl_pkg::SYNC_W)) pins ();

    assign pins.raw = {sys_clk_mon_in, vbus_in, comp_below_in, supply_above_in, rst_pin_n_in};

    pin_sync #(.W(rstctl_pkg::SYNC_W), .RESET_VAL(rstctl_pkg::SYNC_RESET)) u_sync (
        .clock_in(clock_in),
        .rst_n_in(rst_n_in),
        .lanes(pins)
    );

    rstctl_pkg::state_t state_q, state_d;
    logic [7:0] flags_q, flags_d;
    logic mon_en_q, mon_en_d;
    logic sel_q, sel_d;
    logic clk_en_q, clk_en_d;
    logic cmp_en_q, cmp_en_d;
    logic usb_en_q, usb_en_d;
    logic core_q, core_d;
    logic oe_q, oe_d;
    logic [7:0] rd_q, rd_d;
    logic wdt_en_q, wdt_en_d;
    logic [3:0] presc_q, presc_d;
    logic tick_q, tick_d;
    logic clk_prev_q, vbus_prev_q;
    logic [rstctl_pkg::PIN_MASK_CYC-1:0] drive_hist_q, drive_hist_d;
    logic por_done, hold_done, mcd_done;
    logic supply_ok, pin_mask, pin_low, supply_low, vbus_edge, clk_edge;
    logic rs_wr, mon_wr, run;
    logic [7:0] cause;

    assign run = (state_q == rstctl_pkg::ST_RUN);
    assign clk_edge = pins.filt[rstctl_pkg::SI_CLK] ^ clk_prev_q;

    sat_counter #(.LIMIT(POR_DELAY_CYC)) u_por (
        .clock_in(clock_in),
        .rst_n_in(rst_n_in),
        .clear_in(state_q != rstctl_pkg::ST_POR),
        .run_in(1'b1),
        .done_out(por_done)
    );

    // Hold is restarted while pin_low or supply_low is still asserted
    sat_counter #(.LIMIT(rstctl_pkg::HOLD_MIN_CYC)) u_hold (
        .clock_in(clock_in),
        .rst_n_in(rst_n_in),
        .clear_in((state_q != rstctl_pkg::ST_HOLD) || pin_low || supply_low),
        .run_in(1'b1),
        .done_out(hold_done)
    );

    sat_counter #(.LIMIT(MCD_TIMEOUT_CYC)) u_mcd (
        .clock_in(clock_in),
        .rst_n_in(rst_n_in),
        .clear_in(!clk_en_q || !run || clk_edge),
        .run_in(1'b1),
        .done_out(mcd_done)
    );

    // ----------------------------------------
    // Reset requests
    // ----------------------------------------
    always_comb begin
        supply_ok = pins.filt[rstctl_pkg::SI_SUP];
        // Our own drive reads back low; ignore it until the pipe flushes
        pin_mask = oe_q || (|drive_hist_q);
        pin_low = !pins.filt[rstctl_pkg::SI_PIN] && !pin_mask;
        supply_low = mon_en_q && sel_q && !supply_ok;
        vbus_edge = (pins.filt[rstctl_pkg::SI_VBUS] != vbus_prev_q)
            && (pins.filt[rstctl_pkg::SI_VBUS] == vbus_polarity_in);
        rs_wr = wr_en_in && (addr_in == rstctl_pkg::RST_SRC_ADDR) && run;
        mon_wr = wr_en_in && (addr_in == rstctl_pkg::MON_CTRL_ADDR) && run;
        cause = '0;
        cause[rstctl_pkg::RS_PIN] = pin_low;
        cause[rstctl_pkg::RS_PWR] = supply_low;
        cause[rstctl_pkg::RS_CLK] = clk_en_q && mcd_done;
        cause[rstctl_pkg::RS_WDT] = wdt_en_q && wdt_overflow_in;
        cause[rstctl_pkg::RS_SW] = rs_wr && wr_data_in[rstctl_pkg::RS_SW];
        cause[rstctl_pkg::RS_CMP] = cmp_en_q && pins.filt[rstctl_pkg::SI_CMP];
        cause[rstctl_pkg::RS_MEM] = code_access_in && (code_addr_in > CODE_LIMIT);
        cause[rstctl_pkg::RS_USB] = usb_en_q && ((usb_func_en_in && usb_bus_reset_in) || vbus_edge);
        if (!run) begin
            cause = '0;
        end
    end

    // ----------------------------------------
    // Sequencer and reset source register
    // ----------------------------------------
    always_comb begin
        state_d = state_q;
        flags_d = flags_q;
        mon_en_d = mon_en_q;
        sel_d = sel_q;
        clk_en_d = clk_en_q;
        cmp_en_d = cmp_en_q;
        usb_en_d = usb_en_q;
        case (state_q)
            rstctl_pkg::ST_POR: begin
                if (por_done) begin
                    state_d = rstctl_pkg::ST_RUN;
                end
            end
            rstctl_pkg::ST_HOLD: begin
                if (hold_done) begin
                    state_d = rstctl_pkg::ST_RUN;
                end
            end
            rstctl_pkg::ST_RUN: begin
                if (|cause) begin
                    state_d = rstctl_pkg::ST_HOLD;
                    flags_d = cause;
                    clk_en_d = 1'b0;
                    cmp_en_d = 1'b0;
                    usb_en_d = 1'b0;
                end else begin
                    if (rs_wr) begin
                        usb_en_d = wr_data_in[rstctl_pkg::RS_USB];
                        cmp_en_d = wr_data_in[rstctl_pkg::RS_CMP];
                        clk_en_d = wr_data_in[rstctl_pkg::RS_CLK];
                        sel_d = wr_data_in[rstctl_pkg::RS_PWR];
                    end
                    if (mon_wr) begin
                        mon_en_d = wr_data_in[rstctl_pkg::MON_EN_BIT];
                    end
                end
            end
            default: begin
                state_d = rstctl_pkg::ST_POR;
            end
        endcase
        core_d = (state_d == rstctl_pkg::ST_RUN);
        oe_d = (state_d == rstctl_pkg::ST_POR)
            || ((state_d == rstctl_pkg::ST_HOLD) && flags_d[rstctl_pkg::RS_PWR]);
    end

    // Only rst_n_in restores the monitor enable
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_q <= rstctl_pkg::ST_POR;
            flags_q <= rstctl_pkg::FLAGS_POR;
            mon_en_q <= rstctl_pkg::MON_EN_RESET;
            sel_q <= rstctl_pkg::SUPPLY_SEL_RESET;
            clk_en_q <= 1'b0;
            cmp_en_q <= 1'b0;
            usb_en_q <= 1'b0;
            core_q <= 1'b0;
            oe_q <= 1'b1;
        end else begin
            state_q <= state_d;
            flags_q <= flags_d;
            mon_en_q <= mon_en_d;
            sel_q <= sel_d;
            clk_en_q <= clk_en_d;
            cmp_en_q <= cmp_en_d;
            usb_en_q <= usb_en_d;
            core_q <= core_d;
            oe_q <= oe_d;
        end
    end

    // ----------------------------------------
    // Read port, watchdog clocking, edge history
    // ----------------------------------------
    always_comb begin
        rd_d = 8'h00;
        if (rd_en_in && addr_in == rstctl_pkg::MON_CTRL_ADDR) begin
            rd_d[rstctl_pkg::MON_EN_BIT] = mon_en_q;
            rd_d[rstctl_pkg::SUPPLY_OK_BIT] = supply_ok;
        end else if (rd_en_in && addr_in == rstctl_pkg::RST_SRC_ADDR) begin
            rd_d = flags_q;
        end
        wdt_en_d = wdt_en_q;
        if (!run) begin
            wdt_en_d = 1'b1;
        end else if (wdt_disable_in) begin
            wdt_en_d = 1'b0;
        end
        presc_d = 4'h0;
        tick_d = 1'b0;
        if (run && wdt_en_q) begin
            tick_d = (presc_q == 4'(rstctl_pkg::WDT_DIV - 1));
            presc_d = tick_d ? 4'h0 : presc_q + 4'h1;
        end
        drive_hist_d = {drive_hist_q[rstctl_pkg::PIN_MASK_CYC-2:0], oe_q};
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rd_q <= 8'h00;
            wdt_en_q <= 1'b1;
            presc_q <= 4'h0;
            tick_q <= 1'b0;
            clk_prev_q <= rstctl_pkg::SYNC_RESET[rstctl_pkg::SI_CLK];
            vbus_prev_q <= rstctl_pkg::SYNC_RESET[rstctl_pkg::SI_VBUS];
            drive_hist_q <= '1;
        end else begin
            rd_q <= rd_d;
            wdt_en_q <= wdt_en_d;
            presc_q <= presc_d;
            tick_q <= tick_d;
            clk_prev_q <= pins.filt[rstctl_pkg::SI_CLK];
            vbus_prev_q <= pins.filt[rstctl_pkg::SI_VBUS];
            drive_hist_q <= drive_hist_d;
        end
    end

    assign rd_data_out = rd_q;
    assign rst_pin_out = 1'b0 & oe_q;
    assign rst_pin_oe_out = oe_q;
    assign core_rst_n_out = core_q;
    assign monitor_enable_out = mon_en_q;
    assign wdt_enable_out = wdt_en_q;
    assign wdt_tick_out = tick_q;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);

    property p_supply_drive;
        run && supply_low |=> rst_pin_oe_out && !core_rst_n_out && flags_q[rstctl_pkg::RS_PWR];
    endproperty
    a_supply_drive: assert property (p_supply_drive) else $error("supply low did not hold reset");

    property p_mon_kept;
        !run |=> $stable(mon_en_q);
    endproperty
    a_mon_kept: assert property (p_mon_kept) else $error("monitor enable changed in reset");

    property p_needs_select;
        run && !(mon_en_q && sel_q) && (cause & ~8'(1 << rstctl_pkg::RS_PWR)) == 8'h00 |=> core_rst_n_out;
    endproperty
    a_needs_select: assert property (p_needs_select) else $error("reset without selected source");

    property p_no_por_delay;
        state_q == rstctl_pkg::ST_HOLD |=> state_q != rstctl_pkg::ST_POR;
    endproperty
    a_no_por_delay: assert property (p_no_por_delay) else $error("power-on delay after hold");

    property p_status_read;
        rd_en_in && addr_in == rstctl_pkg::MON_CTRL_ADDR
            |=> rd_data_out[rstctl_pkg::SUPPLY_OK_BIT] == $past(supply_ok) && rd_data_out[5:0] == 6'h00;
    endproperty
    a_status_read: assert property (p_status_read) else $error("monitor status read wrong");

    property p_pin_flag;
        run && pin_low |=> flags_q[rstctl_pkg::RS_PIN] && !core_rst_n_out;
    endproperty
    a_pin_flag: assert property (p_pin_flag) else $error("pin reset not flagged");

    property p_pin_quiet;
        rst_pin_oe_out |-> state_q == rstctl_pkg::ST_POR
            || (state_q == rstctl_pkg::ST_HOLD && flags_q[rstctl_pkg::RS_PWR]);
    endproperty
    a_pin_quiet: assert property (p_pin_quiet) else $error("pin driven by internal reset");

    property p_cmp_reset;
        run && cmp_en_q && pins.filt[rstctl_pkg::SI_CMP]
            |=> flags_q[rstctl_pkg::RS_CMP] && !core_rst_n_out ##1 !cmp_en_q;
    endproperty
    a_cmp_reset: assert property (p_cmp_reset) else $error("comparator reset missed");

    property p_sw_force;
        rs_wr && wr_data_in[rstctl_pkg::RS_SW] |=> flags_q[rstctl_pkg::RS_SW] && !core_rst_n_out;
    endproperty
    a_sw_force: assert property (p_sw_force) else $error("software force ignored");

    property p_wdt_after;
        $rose(core_rst_n_out) |-> wdt_enable_out;
    endproperty
    a_wdt_after: assert property (p_wdt_after) else $error("watchdog off after reset");

    property p_one_cause_clears;
        run && cause != 8'h00 |=> flags_q == $past(cause);
    endproperty
    a_one_cause_clears: assert property (p_one_cause_clears) else $error("cause flags not replaced");

    c_supply: cover property (run && supply_low ##[1:40] core_rst_n_out);
    c_mcd: cover property (run && clk_en_q && mcd_done);
    c_usb: cover property (run && usb_en_q && vbus_edge);
    c_por_exit: cover property ($rose(core_rst_n_out) && flags_q == rstctl_pkg::FLAGS_POR);

endmodule : reset_source_controller

// ### dv/board_model.sv
/*
 Board side of the reset controller: pulled-up reset pin with an
 external low driver, and the monitored system clock lane.
 Assumes it shares clock_in with the controller under test.
*/
module board_model (
    // Clock
    input wire logic clock_in,
    // Reset pin
    input wire logic oe_in,
    input wire logic ext_low_in,
    output logic pin_n_out,
    // System clock lane
    input wire logic stall_in,
    output logic sys_clk_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------
    // Pin and clock
    // ----------------------------------------
    logic [1:0] div_q = 2'h0;
    // Pull-up wins unless either party pulls low
    assign pin_n_out = !(oe_in || ext_low_in);
    // Slow toggle, so the agreement filter keeps every edge
    always @(posedge clock_in) begin
        if (!stall_in) begin
            div_q <= div_q + 2'h1;
        end
    end
    assign sys_clk_out = div_q[1];
endmodule : board_model

// ### dv/tb_top.sv
/*
 Self-checking bench of the reset source controller.
 Assumes the board model drives the pin and system clock lanes.
*/
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic clock_in = 0, rst_n_in = 0, wr_en_in = 0, rd_en_in = 0;
    logic [7:0] addr_in = 8'h00, wr_data_in = 8'h00, rd_data_out;
    logic rst_pin_n_in, rst_pin_out, rst_pin_oe_out, sys_clk_mon_in;
    logic supply_above_in = 1, comp_below_in = 0, vbus_in = 0;
    logic wdt_overflow_in = 0, wdt_disable_in = 0, code_access_in = 0;
    logic [15:0] code_addr_in = 16'h0000;
    logic usb_func_en_in = 1, usb_bus_reset_in = 0, vbus_polarity_in = 1;
    logic core_rst_n_out, monitor_enable_out, wdt_enable_out, wdt_tick_out;
    logic pin_low = 0, stall = 0;
    logic [7:0] mc = rstctl_pkg::MON_CTRL_ADDR, rs = rstctl_pkg::RST_SRC_ADDR, a;
    logic [31:0] seed = 32'h387f734d;
    logic [7:0] efl[9] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80, 8'h80};
    logic [7:0] cfg[9] = '{8'h00, 8'h00, 8'h06, 8'h00, 8'h12, 8'h22, 8'h00, 8'h82, 8'h82};
    int mismatches = 0, num_checks = 0, n, mon_m = 1;
    int exp_q[$];

    reset_source_controller #(.POR_DELAY_CYC(20), .MCD_TIMEOUT_CYC(16)) i_reset_source_controller (
        .clock_in, .rst_n_in, .addr_in, .wr_data_in, .wr_en_in, .rd_en_in, .rd_data_out,
        .rst_pin_n_in, .rst_pin_out, .rst_pin_oe_out, .supply_above_in, .comp_below_in,
        .vbus_in, .sys_clk_mon_in, .wdt_overflow_in, .wdt_disable_in, .code_access_in,
        .code_addr_in, .usb_func_en_in, .usb_bus_reset_in, .vbus_polarity_in,
        .core_rst_n_out, .monitor_enable_out, .wdt_enable_out, .wdt_tick_out);
    board_model i_board_model (.clock_in, .oe_in(rst_pin_oe_out), .ext_low_in(pin_low),
        .pin_n_out(rst_pin_n_in), .stall_in(stall), .sys_clk_out(sys_clk_mon_in));

    always #25 clock_in = ~clock_in;
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs

    task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask : cmp

    task automatic cmp1(input string nm, input logic e, input logic g);
        num_checks++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %s exp %b got %b", nm, e, g);
        end
    endtask : cmp1

    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        @(posedge clock_in);
        addr_in <= ad;
        wr_data_in <= d;
        wr_en_in <= 1;
        @(posedge clock_in);
        wr_en_in <= 0;
    endtask : wr

    task automatic rd(input logic [7:0] ad, input logic [7:0] e, input string nm);
        @(posedge clock_in);
        addr_in <= ad;
        rd_en_in <= 1;
        @(posedge clock_in);
        rd_en_in <= 0;
        #1;
        cmp(nm, e, rd_data_out);
    endtask : rd

    // Bounded wait on the core reset (0) or the watchdog tick (1)
    task automatic wait_for(input int w, input logic v, input int lim);
        n = 0;
        while ((w ? wdt_tick_out : core_rst_n_out) !== v && n < lim) begin
            @(posedge clock_in);
            #1;
            n++;
        end
    endtask : wait_for

    task automatic fire(input int c);
        exp_q.push_back(int'(efl[c]));
        if (cfg[c] != 8'h00) begin
            wr(rs, cfg[c]);
        end
        @(posedge clock_in);
        case (c)
            0: pin_low <= 1;
            1: supply_above_in <= 0;
            2: stall <= 1;
            3: wdt_overflow_in <= 1;
            5: comp_below_in <= 1;
            6: code_access_in <= 1;
            7: usb_bus_reset_in <= 1;
            8: vbus_in <= 1;
            default: ;
        endcase
        @(posedge clock_in);
        wdt_overflow_in <= 0;
        code_access_in <= 0;
        wait_for(0, 0, 60);
        cmp1("core_rst_n_out", 0, core_rst_n_out);
        if (c == 1) begin
            rd(mc, {mon_m[0], 7'h00}, "mon_ctrl");
        end
        if (c > 0) begin
            cmp1("rst_pin_oe_out", c == 1, rst_pin_oe_out);
        end
        cmp1("rst_pin_out", 0, rst_pin_out);
        @(posedge clock_in);
        pin_low <= 0;
        supply_above_in <= 1;
        stall <= 0;
        comp_below_in <= 0;
        usb_bus_reset_in <= 0;
        wait_for(0, 1, 16);
        cmp1("core_rst_n_out", 1, core_rst_n_out);
        rd(rs, 8'(exp_q.pop_front()), "flags");
        cmp1("wdt_enable_out", 1, wdt_enable_out);
    endtask : fire

    task automatic finish_test();
        if (mismatches == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : finish_test
    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        repeat (4) @(posedge clock_in);
        rst_n_in <= 1;
        wait_for(0, 1, 40);
        cmp1("por_delay", 1, n >= 20);
        cmp1("rst_pin_oe_out", 0, rst_pin_oe_out);
        rd(rs, 8'h02, "flags");
        rd(mc, 8'hc0, "mon_ctrl");
        wait_for(1, 1, 30);
        @(posedge clock_in);
        #1;
        wait_for(1, 1, 30);
        cmp("tick_gap", 8'(rstctl_pkg::WDT_DIV), 8'(n + 1));
        // Monitor off: a low supply must not reset
        wr(mc, 8'h00);
        mon_m = 0;
        supply_above_in <= 0;
        repeat (12) @(posedge clock_in);
        rd(mc, 8'h00, "mon_ctrl");
        cmp1("core_rst_n_out", 1, core_rst_n_out);
        @(posedge clock_in);
        supply_above_in <= 1;
        repeat (6) @(posedge clock_in);
        fire(4);
        rd(mc, 8'h40, "mon_ctrl");
        cmp1("monitor_enable_out", 0, monitor_enable_out);
        wr(mc, 8'h80);
        mon_m = 1;
        // Disabled watchdog ignores its overflow
        wdt_disable_in <= 1;
        @(posedge clock_in);
        wdt_disable_in <= 0;
        wdt_overflow_in <= 1;
        @(posedge clock_in);
        wdt_overflow_in <= 0;
        repeat (4) @(posedge clock_in);
        cmp1("core_rst_n_out", 1, core_rst_n_out);
        cmp1("wdt_enable_out", 0, wdt_enable_out);
        // Accesses up to the limit stay legal
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            code_access_in <= 1;
            code_addr_in <= (i == 0) ? 16'h7fff : {1'b0, seed[14:0]};
            @(posedge clock_in);
        end
        code_access_in <= 0;
        code_addr_in <= 16'h8000;
        repeat (3) @(posedge clock_in);
        cmp1("core_rst_n_out", 1, core_rst_n_out);
        for (int c = 0; c < 9; c++) begin
            fire(c);
        end
        wr(rs, 8'h4a);
        rd(rs, 8'h80, "flags");
        for (int i = 0; i < 4; i++) begin
            seed = xs(seed);
            wr(mc, seed[7:0]);
            rd(mc, {seed[7], 7'h40}, "mon_ctrl");
            cmp1("monitor_enable_out", seed[7], monitor_enable_out);
            a = seed[15:8];
            if (a == mc || a == rs) begin
                a = 8'h00;
            end
            rd(a, 8'h00, "unmapped");
        end
        // Power-on reset in mid-run turns the monitor back on
        wr(mc, 8'h00);
        rst_n_in <= 0;
        repeat (2) @(posedge clock_in);
        rst_n_in <= 1;
        wait_for(0, 1, 40);
        cmp1("por_delay", 1, n >= 20);
        rd(mc, 8'hc0, "mon_ctrl");
        rd(rs, 8'h02, "flags");
        finish_test();
    end

    initial begin
        repeat (6000) @(posedge clock_in);
        mismatches++;
        finish_test();
    end
endmodule : tb_top
